// ===== tsm_ctrl.sv
/*
 tsm_ctrl: slot-bus controller for a dual-line framer module. Holds the
 module's clock settings, the slot connection map and the frame timing.
 Assumes a classic Wishbone master and a module that obeys its pins.
*/
// The register addresses and the Wishbone slave port were chosen for this implementation.
// Behaviour
// - framer interrupt 1 on elastic store slip must be enabled too.
// - one bus clock driver only; none on base, exactly one on module.
// - clock parameter 0 for external clock, else 2, 4 or 8.
// - eight bits per slot whenever framer traffic is carried.
// - sixteen frames per multiframe.
// - every frame lasts 125 us: 32, 64 or 128 slots; own clock gives 122.88 us at 32 or 64 slots, 81.92 us at 128.
// - resync each used receive line after start and every restart.
// - all 32 data slots of each line handled every frame.
// - one source per bus per slot; delete by slot and bus.
// - one destination bus per device per slot; delete by slot, device.
// - special entry unloads elastic store word without driving a bus.
`timescale 1ns/1ps
module tsm_ctrl
	import tsm_pkg::*;
#(
	parameter int         N_ENT    = 16,
	parameter logic [7:0] DIV_HALF = 8'h06
)
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic [31:0]      wb_dat_r,
	output logic             wb_ack,
	input  wire logic [3:0]  module_revision,
	input  wire logic        bus_clk_in,
	output logic             bus_clk_out,
	output logic             bus_clk_oe_n,
	output logic [1:0]       rcv_clk_sel,
	output logic [1:0]       clk_ratio,
	output logic [3:0]       xmt_clk_sel,
	output logic [1:0]       slip_inval,
	output logic [1:0]       slip_irq_en,
	output logic [1:0]       rsync_req,
	output logic             frame_sync,
	output logic             mframe_sync,
	output logic [7:0]       cur_slot,
	output logic [3:0]       src_valid,
	output logic [19:0]      src_dev,
	output logic [3:0]       dst_valid,
	output logic             unload_valid,
	output logic [4:0]       unload_dev
);

	logic [31:0] ctrl_q, ctrl_d, rdat_d;
	logic        ack_d, req, wr_ctl, wr_cmd;
	logic        err_q, err_d, fail_q, fail_d;
	tsm_st_e     st_q, st_d;

	assign req    = wb_cyc && wb_stb && !wb_ack;
	assign wr_ctl = ce && req && wb_we && wb_adr == A_CTRL;
	assign wr_cmd = ce && req && wb_we && wb_adr == A_CMD;

	logic [1:0] ratio;
	logic       mod_src;
	logic [7:0] slots;
	logic [3:0] ck_par;
	assign ratio   = ctrl_q[C_RAT +: 2];
	assign mod_src = ctrl_q[C_SRC];
	assign slots   = BASE_SLOTS << ratio;
	assign ck_par  = mod_src ? 4'h0 : (CK_BASE << ratio);

	// bus clock sampling and presence
	logic       ck_s, ck_p_q, ck_rise, present;
	logic [7:0] loss_q, loss_d;

	tsm_sync u_ck (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.d       (bus_clk_in),
		.q       (ck_s)
	);

	assign ck_rise = ck_s && !ck_p_q;
	assign present = loss_q < 8'(LOSS_CYC);

	// own clock output, used only with the internal base source
	logic [7:0] div_q, div_d;
	logic       co_q, co_d;

	// slot timing
	logic [2:0] bit_q, bit_d;
	logic [7:0] slot_q, slot_d;
	logic [3:0] frm_q, frm_d;
	logic       fs_d, mf_d;
	logic [1:0] rs_d;

	always_comb
	begin
		loss_d = loss_q;
		div_d  = div_q;
		co_d   = co_q;
		if (ck_rise)
			loss_d = 8'h00;
		else if (present)
			loss_d = loss_q + 8'h01;
		// the ratio shifts the half period; odd rates are approximate
		if (div_q >= (DIV_HALF >> ratio) - 8'h01)
		begin
			div_d = 8'h00;
			co_d  = !co_q;
		end
		else
			div_d = div_q + 8'h01;
	end

	always_comb
	begin
		st_d   = st_q;
		fail_d = fail_q;
		bit_d  = bit_q;
		slot_d = slot_q;
		frm_d  = frm_q;
		fs_d   = 1'b0;
		mf_d   = 1'b0;
		rs_d   = 2'b00;
		case (st_q)
			ST_IDLE:
			begin
				if (ctrl_q[C_RUN] && present)
				begin
					st_d   = ST_START;
					fail_d = 1'b0;
				end
				else if (ctrl_q[C_RUN])
				begin
					st_d   = ST_FAIL;
					fail_d = 1'b1;
				end
			end
			ST_START:
			begin
				st_d   = ST_RUN;
				bit_d  = 3'h0;
				slot_d = 8'h01;
				frm_d  = 4'h0;
				fs_d   = 1'b1;
				mf_d   = 1'b1;
				rs_d   = ctrl_q[C_USE +: 2];
			end
			ST_RUN:
			begin
				if (!ctrl_q[C_RUN])
					st_d = ST_IDLE;
				else if (ck_rise)
				begin
					bit_d = bit_q + 3'h1;
					if (bit_q == BIT_LAST)
					begin
						slot_d = slot_q + 8'h01;
						if (slot_q == slots)
						begin
							slot_d = 8'h01;
							frm_d  = frm_q + 4'h1;
							fs_d   = 1'b1;
							mf_d   = frm_q == MF_LAST;
						end
					end
				end
			end
			ST_FAIL:
			begin
				if (!ctrl_q[C_RUN])
					st_d = ST_IDLE;
			end
			default:
				st_d = ST_IDLE;
		endcase
	end

	// connection map
	logic [N_ENT-1:0] ev_q, ev_d, mt;
	tsm_kind_e        ek_q [N_ENT];
	tsm_kind_e        ek_d [N_ENT];
	logic [1:0]       eb_q [N_ENT];
	logic [1:0]       eb_d [N_ENT];
	logic [4:0]       ed_q [N_ENT];
	logic [4:0]       ed_d [N_ENT];
	logic [7:0]       es_q [N_ENT];
	logic [7:0]       es_d [N_ENT];

	tsm_op_e    c_op;
	tsm_kind_e  c_kind;
	logic [7:0] c_slot;
	logic [1:0] c_bus;
	logic [4:0] c_dev;
	logic       c_add, c_bad;
	logic [2:0] c_opm1;
	assign c_op   = tsm_op_e'(wb_dat_w[K_OP +: 3]);
	assign c_slot = wb_dat_w[K_SLOT +: 8];
	assign c_bus  = wb_dat_w[K_BUS +: 2];
	assign c_dev  = wb_dat_w[K_DEV +: 5];
	assign c_add  = c_op[0];
	assign c_opm1 = c_op - 3'h1;
	assign c_kind = tsm_kind_e'(c_opm1[2:1]);
	assign c_bad  = c_op == OP_NOP || c_op == 3'b111
		|| c_slot == 8'h00 || c_slot > slots
		|| !SITE_OK[c_dev[3:0]];

	always_comb
	begin
		for (int i = 0; i < N_ENT; i++)
			// sources match on slot and bus, others on slot and device
			mt[i] = ev_q[i] && es_q[i] == c_slot && ek_q[i] == c_kind
				&& (c_kind == K_SRC ? eb_q[i] == c_bus
				                    : ed_q[i] == c_dev);
	end

	always_comb
	begin
		logic hit;
		hit   = 1'b0;
		ev_d  = ev_q;
		ek_d  = ek_q;
		eb_d  = eb_q;
		ed_d  = ed_q;
		es_d  = es_q;
		err_d = err_q;
		if (wr_cmd)
		begin
			err_d = c_bad || (c_add ? |mt : !(|mt)) || (c_add && &ev_q);
			if (!err_d && c_add)
			begin
				for (int i = 0; i < N_ENT; i++)
					if (!ev_q[i] && !hit)
					begin
						hit     = 1'b1;
						ev_d[i] = 1'b1;
						ek_d[i] = c_kind;
						eb_d[i] = c_bus;
						ed_d[i] = c_dev;
						es_d[i] = c_slot;
					end
			end
			else if (!err_d)
				ev_d = ev_q & ~mt;
		end
	end

	// per-bus slot view, registered for the pins
	logic [3:0]  sv_d, dv_d;
	logic [19:0] sd_d;
	logic        uv_d;
	logic [4:0]  ud_d;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_bus
			always_comb
			begin
				sv_d[g]         = 1'b0;
				dv_d[g]         = 1'b0;
				sd_d[g*5 +: 5]  = 5'h00;
				for (int i = 0; i < N_ENT; i++)
					if (ev_q[i] && es_q[i] == slot_q && eb_q[i] == 2'(g))
					begin
						if (ek_q[i] == K_SRC)
						begin
							sv_d[g]        = 1'b1;
							sd_d[g*5 +: 5] = ed_q[i];
						end
						if (ek_q[i] == K_DST)
							dv_d[g] = 1'b1;
					end
			end
		end
	endgenerate

	always_comb
	begin
		uv_d = 1'b0;
		ud_d = 5'h00;
		for (int i = 0; i < N_ENT; i++)
			if (ev_q[i] && es_q[i] == slot_q && ek_q[i] == K_SPC)
			begin
				uv_d = 1'b1;
				ud_d = ed_q[i];
			end
	end

	// register file
	always_comb
	begin
		ctrl_d = ctrl_q;
		ack_d  = ce ? req : wb_ack;
		rdat_d = wb_dat_r;
		if (wr_ctl)
			for (int b = 0; b < 4; b++)
				if (wb_sel[b])
					ctrl_d[b*8 +: 8] = wb_dat_w[b*8 +: 8];
		if (ce && req)
		begin
			rdat_d = 32'h0000_0000;
			if (wb_adr == A_CTRL)
				rdat_d = ctrl_q;
			else if (wb_adr == A_STAT)
			begin
				rdat_d[S_RUN]       = st_q == ST_RUN;
				rdat_d[S_CLK]       = present;
				rdat_d[S_FAIL]      = fail_q;
				rdat_d[S_ERR]       = err_q;
				rdat_d[S_PAR +: 4]  = ck_par;
				rdat_d[S_SLOT +: 8] = slot_q;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RST;
			wb_ack <= 1'b0;
			wb_dat_r <= 32'h0000_0000;
			err_q  <= 1'b0;
			fail_q <= 1'b0;
			st_q   <= ST_IDLE;
			ck_p_q <= 1'b0;
			loss_q <= 8'(LOSS_CYC);
			div_q  <= 8'h00;
			co_q   <= 1'b0;
			bit_q  <= 3'h0;
			slot_q <= 8'h01;
			frm_q  <= 4'h0;
			frame_sync  <= 1'b0;
			mframe_sync <= 1'b0;
			rsync_req   <= 2'b00;
			src_valid   <= 4'h0;
			src_dev     <= 20'h00000;
			dst_valid   <= 4'h0;
			unload_valid <= 1'b0;
			unload_dev  <= 5'h00;
			ev_q   <= '0;
			for (int i = 0; i < N_ENT; i++)
			begin
				ek_q[i] <= K_SRC;
				eb_q[i] <= 2'h0;
				ed_q[i] <= 5'h00;
				es_q[i] <= 8'h00;
			end
		end
		else if (ce)
		begin
			ctrl_q <= ctrl_d;
			wb_ack <= ack_d;
			wb_dat_r <= rdat_d;
			err_q  <= err_d;
			fail_q <= fail_d;
			st_q   <= st_d;
			ck_p_q <= ck_s;
			loss_q <= loss_d;
			div_q  <= div_d;
			co_q   <= co_d;
			bit_q  <= bit_d;
			slot_q <= slot_d;
			frm_q  <= frm_d;
			frame_sync  <= fs_d;
			mframe_sync <= mf_d;
			rsync_req   <= rs_d;
			src_valid   <= sv_d;
			src_dev     <= sd_d;
			dst_valid   <= dv_d;
			unload_valid <= uv_d;
			unload_dev  <= ud_d;
			ev_q   <= ev_d;
			ek_q   <= ek_d;
			eb_q   <= eb_d;
			ed_q   <= ed_d;
			es_q   <= es_d;
		end
	end

	// the revision pins are straps, but they still cross into this domain
	logic [3:0] rev_s;
	genvar r;
	generate
		for (r = 0; r < 4; r++)
		begin : g_rev
			tsm_sync u_rev (
				.sys_clk (sys_clk),
				.rst     (rst),
				.ce      (ce),
				.d       (module_revision[r]),
				.q       (rev_s[r])
			);
		end
	endgenerate

	// module pins; with the base source no module may drive the clock
	logic slip_ok;
	assign slip_ok      = rev_s >= REV_MIN;
	assign rcv_clk_sel  = mod_src ? ctrl_q[C_RCV +: 2] : 2'b00;
	assign clk_ratio    = ratio;
	assign xmt_clk_sel  = ctrl_q[C_XMT +: 4];
	assign slip_inval   = slip_ok ? ctrl_q[C_SLP +: 2] : 2'b00;
	assign slip_irq_en  = slip_inval;
	assign bus_clk_out  = co_q;
	assign bus_clk_oe_n = mod_src;
	assign cur_slot     = slot_q;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	ack_one_cycle_a: assert property (ce && wb_ack |=> !wb_ack)
		else $error("ack held longer than one cycle");
	base_no_module_a: assert property (!mod_src |-> rcv_clk_sel == 2'b00)
		else $error("module drives clock while base source selected");
	own_drive_a: assert property (ce && !bus_clk_oe_n
		|-> ##[1:256] $changed(bus_clk_out))
		else $error("own bus clock not toggling while driven");
	clk_param_a: assert property (ce && req && wb_adr == A_STAT
		|=> wb_dat_r[S_PAR +: 4] inside {4'h2, 4'h4, 4'h8}
		|| ($past(mod_src) && wb_dat_r[S_PAR +: 4] == 4'h0))
		else $error("clock parameter outside 0, 2, 4 or 8");
	slip_rev_a: assert property (slip_inval != 2'b00 |->
		rev_s >= REV_MIN && slip_irq_en == slip_inval)
		else $error("slip invalidation without revision or interrupt");
	frame_wrap_a: assert property (ce && st_q == ST_RUN && ctrl_q[C_RUN]
		&& ck_rise && bit_q == BIT_LAST && slot_q == slots
		|=> frame_sync && slot_q == 8'h01)
		else $error("frame did not wrap after last slot");
	mframe_a: assert property (mframe_sync |-> frame_sync
		&& (frm_q == 4'h0))
		else $error("multiframe sync out of place");
	resync_a: assert property (ce && st_q == ST_START
		|=> rsync_req == $past(ctrl_q[C_USE +: 2]) && st_q == ST_RUN)
		else $error("resync not requested at start");
	run_clock_a: assert property (ce && st_q == ST_IDLE && ctrl_q[C_RUN]
		&& !present |=> st_q == ST_FAIL && fail_q)
		else $error("run accepted without bus clock");
	slot_range_a: assert property (slot_q >= 8'h01 && slot_q <= 8'h80)
		else $error("slot number out of range");

endmodule

// ===== tsm_pkg.sv
/*
 tsm_pkg: constants and types shared by the slot-bus controller and its
 input synchroniser. Assumes a 25 MHz system clock.
*/
package tsm_pkg;

	localparam int unsigned SYS_NS   = 40;
	// slot-bus clock counts as absent after this long without an edge
	localparam int unsigned LOSS_NS  = 2000;
	localparam int unsigned LOSS_CYC = (LOSS_NS + SYS_NS - 1) / SYS_NS;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_CMD  = 8'h08;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// control register fields
	localparam int C_RUN = 0;
	localparam int C_SRC = 1;
	localparam int C_RAT = 2;
	localparam int C_RCV = 4;
	localparam int C_XMT = 6;
	localparam int C_SLP = 10;
	localparam int C_USE = 12;

	// status register fields
	localparam int S_RUN  = 0;
	localparam int S_CLK  = 1;
	localparam int S_FAIL = 2;
	localparam int S_ERR  = 3;
	localparam int S_PAR  = 8;
	localparam int S_SLOT = 16;

	// map command fields
	localparam int K_SLOT = 0;
	localparam int K_BUS  = 8;
	localparam int K_DEV  = 16;
	localparam int K_OP   = 24;

	localparam logic [2:0]  BIT_LAST   = 3'h7;
	localparam logic [3:0]  MF_LAST    = 4'hf;
	localparam logic [7:0]  BASE_SLOTS = 8'h20;
	localparam logic [3:0]  CK_BASE    = 4'h2;
	localparam logic [3:0]  REV_MIN    = 4'h2;
	localparam logic [15:0] SITE_OK    = 16'h002f;

	typedef enum logic [2:0] {
		OP_NOP     = 3'b000,
		OP_SRC_ADD = 3'b001,
		OP_SRC_DEL = 3'b010,
		OP_DST_ADD = 3'b011,
		OP_DST_DEL = 3'b100,
		OP_SPC_ADD = 3'b101,
		OP_SPC_DEL = 3'b110
	} tsm_op_e;

	typedef enum logic [1:0] {
		K_SRC = 2'b00,
		K_DST = 2'b01,
		K_SPC = 2'b10
	} tsm_kind_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_RUN   = 2'b10,
		ST_FAIL  = 2'b11
	} tsm_st_e;

endpackage

// ===== tsm_sync.sv
/*
 tsm_sync: two-stage synchroniser for one level from another domain.
 Assumes the input is a slow level such as the sampled slot-bus clock.
*/
`timescale 1ns/1ps
module tsm_sync
	import tsm_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic d,
	output logic      q
);

	logic m_q;
	logic m_d;
	logic q_d;

	always_comb
	begin
		m_d = ce ? d : m_q;
		q_d = ce ? m_q : q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			m_q <= 1'b0;
			q   <= 1'b0;
		end
		else
		begin
			m_q <= m_d;
			q   <= q_d;
		end
	end

endmodule

// ===== tsm_mod_model.sv
/*
 tsm_mod_model: behavioural dual-line framer module on the slot bus.
 Assumes the bench resolves the shared bus clock wire from both enables.
*/
`timescale 1ns/1ps
module tsm_mod_model
	import tsm_pkg::*;
(
	input  wire logic [1:0] rcv_clk_sel,
	input  wire logic [1:0] clk_ratio,
	input  wire logic [3:0] xmt_clk_sel,
	input  wire logic [1:0] slip_inval,
	input  wire logic [3:0] module_revision,
	input  wire logic       bus_clk,
	output logic            clk_out,
	output logic            clk_oe_n,
	output logic [1:0]      line_transmit_clock,
	output logic [1:0]      slip_on
);
	logic [1:0] div_q = 2'h0;
	logic       der;

	// one recovered clock serves both lines, so the faster pick is trivial
	initial
	begin
		clk_out = 1'b0;
		forever
		begin
			// an unknown ratio before reset falls back to the slowest rate
			if (clk_ratio == 2'h2)
				#40;
			else if (clk_ratio == 2'h1)
				#80;
			else
				#160;
			clk_out = (rcv_clk_sel != 2'h0) ? ~clk_out : 1'b0;
		end
	end
	assign clk_oe_n = (rcv_clk_sel == 2'h0);
	always @(posedge bus_clk)
		div_q <= div_q + 2'h1;
	// derived transmit clock comes back down to the base line rate
	assign der = (clk_ratio == 2'h0) ? bus_clk : div_q[clk_ratio - 2'h1];
	assign line_transmit_clock[1] = (xmt_clk_sel[3:2] == 2'b10) && der;
	assign line_transmit_clock[0] = (xmt_clk_sel[1:0] == 2'b10) && der;
	assign slip_on = (module_revision >= REV_MIN) ? slip_inval : 2'h0;
endmodule

// ===== testbench.sv
/*
 testbench: drives the slot-bus controller over Wishbone beside a model
 of the framer module. Assumes tsm_pkg, tsm_ctrl and tsm_mod_model.
*/
`timescale 1ns/1ps
module testbench
	import tsm_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'hf;
	logic [31:0] wb_dat_w = 32'h0;
	logic [3:0]  module_revision = 4'h2;
	logic [31:0] wb_dat_r;
	logic        wb_ack, bus_clk_out, bus_clk_oe_n, frame_sync, mframe_sync;
	logic        unload_valid, mod_clk, mod_oe_n, bus_wire, wire_q;
	logic [1:0]  rcv_clk_sel, clk_ratio, slip_inval, slip_irq_en, rsync_req;
	logic [3:0]  xmt_clk_sel, src_valid, dst_valid;
	logic [7:0]  cur_slot;
	logic [19:0] src_dev;
	logic [4:0]  unload_dev;
	logic [15:0] rnd = 16'hc996;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic        clash = 1'b0;
	int          error_cnt = 0;
	int          tests_run = 0;

	tsm_ctrl #(.N_ENT(16), .DIV_HALF(8'h06)) tsm_ctrl_inst (.sys_clk, .rst,
		.ce, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
		.wb_dat_r, .wb_ack, .module_revision, .bus_clk_in(bus_wire),
		.bus_clk_out, .bus_clk_oe_n, .rcv_clk_sel, .clk_ratio, .xmt_clk_sel,
		.slip_inval, .slip_irq_en, .rsync_req, .frame_sync, .mframe_sync,
		.cur_slot, .src_valid, .src_dev, .dst_valid, .unload_valid,
		.unload_dev);
	tsm_mod_model tsm_mod_model_inst (.rcv_clk_sel, .clk_ratio,
		.xmt_clk_sel, .slip_inval, .module_revision, .bus_clk(bus_wire),
		.clk_out(mod_clk), .clk_oe_n(mod_oe_n), .line_transmit_clock(),
		.slip_on());

	// nobody driving leaves the wire at its pull-down level
	assign bus_wire = !bus_clk_oe_n ? bus_clk_out : (!mod_oe_n && mod_clk);

	initial forever #20 sys_clk = ~sys_clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		// only the watchdog ends a wait for the answer
		do
			@(posedge sys_clk);
		while (wb_ack !== 1'b1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		wb(1'b0, a, 32'h0);
	endtask

	task automatic cmd(input logic [2:0] op, input logic [7:0] sl,
		input logic [1:0] bs, input logic [4:0] dv, input logic er);
		wb(1'b1, A_CMD, {5'h0, op, 3'h0, dv, 6'h0, bs, sl});
		rd(A_STAT, {28'h0, er, 3'h0}, 32'h8);
	endtask

	// clears run, waits out the presence window, then starts again
	task automatic run(input logic [31:0] c, input logic ok);
		logic [3:0] seen;
		logic [3:0] p;
		int         n;
		int         cnt;
		seen = 4'h0;
		p = c[1] ? 4'h0 : (4'h2 << c[3:2]);
		wb(1'b1, A_CTRL, c);
		repeat (60) @(posedge sys_clk);
		wb(1'b1, A_CTRL, c | 32'h1);
		for (n = 0; n < 20; n++)
		begin
			seen = seen | {frame_sync, mframe_sync, rsync_req};
			@(posedge sys_clk);
		end
		chk(32'(seen), {28'h0, ok, ok, ok ? c[13:12] : 2'b00});
		rd(A_STAT, {20'h0, p, 5'h0, ~ok, ok, ok}, 32'h0f07);
		if (ok)
		begin
			for (n = 0; n < 9000 && frame_sync !== 1'b1; n++)
				@(posedge sys_clk);
			cnt = 0;
			do
			begin
				@(posedge sys_clk);
				n++;
				if (bus_wire && !wire_q)
					cnt++;
			end
			while (frame_sync !== 1'b1 && n < 20000);
			chk(32'(cnt), 32'(256 << c[3:2]));
		end
	endtask

	always @(posedge sys_clk)
	begin
		wire_q <= bus_wire;
		if (!bus_clk_oe_n && !mod_oe_n)
			clash <= 1'b1;
		if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
			chk(wb_dat_r & msk_q.pop_front(), exp_q.pop_front());
	end

	initial
	begin
		int          i;
		logic [31:0] v;
		logic [1:0]  e;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(A_CTRL, CTRL_RST, 32'hffffffff);
		chk(32'(bus_clk_oe_n), 32'h0);
		rd(8'h0c, 32'h0, 32'hffffffff);
		for (i = 0; i < 8; i++)
		begin
			rnd = lfsr(rnd);
			v = {18'h0, rnd[13:4], rnd[3] & ~rnd[2], rnd[2], rnd[1], 1'b0};
			module_revision <= i[0] ? 4'h1 : 4'h2;
			wb(1'b1, A_CTRL, v);
			e = i[0] ? 2'h0 : v[11:10];
			chk(32'(clk_ratio), 32'(v[3:2]));
			chk(32'(xmt_clk_sel), 32'(v[9:6]));
			chk(32'(rcv_clk_sel), v[1] ? 32'(v[5:4]) : 32'h0);
			chk(32'(bus_clk_oe_n), 32'(v[1]));
			chk(32'({slip_irq_en, slip_inval}), 32'({e, e}));
			rd(A_CTRL, v, 32'h3fff);
		end
		module_revision <= 4'h2;
		wb(1'b1, A_CTRL, 32'h0);
		cmd(3'h1, 8'h03, 2'h2, 5'h02, 1'b0);
		cmd(3'h1, 8'h03, 2'h2, 5'h12, 1'b1);
		cmd(3'h3, 8'h03, 2'h1, 5'h12, 1'b0);
		cmd(3'h3, 8'h03, 2'h3, 5'h12, 1'b1);
		cmd(3'h5, 8'h04, 2'h0, 5'h15, 1'b0);
		cmd(3'h1, 8'h00, 2'h0, 5'h03, 1'b1);
		cmd(3'h1, 8'h21, 2'h0, 5'h03, 1'b1);
		cmd(3'h1, 8'h20, 2'h0, 5'h03, 1'b0);
		cmd(3'h1, 8'h05, 2'h3, 5'h04, 1'b1);
		cmd(3'h0, 8'h05, 2'h3, 5'h00, 1'b1);
		cmd(3'h7, 8'h05, 2'h3, 5'h00, 1'b1);
		cmd(3'h2, 8'h07, 2'h0, 5'h00, 1'b1);
		cmd(3'h2, 8'h20, 2'h0, 5'h00, 1'b0);
		cmd(3'h4, 8'h03, 2'h0, 5'h12, 1'b0);
		cmd(3'h3, 8'h03, 2'h1, 5'h12, 1'b0);
		cmd(3'h1, 8'h06, 2'h3, 5'h00, 1'b0);
		run(32'h0000_3004, 1'b1);
		run(32'h0000_1002, 1'b0);
		for (i = 1; i < 4; i++)
			run(32'h0000_2002 | (32'(i) << 4), 1'b1);
		for (i = 0; i < 4000 && src_valid[2] !== 1'b1; i++)
			@(posedge sys_clk);
		chk({16'h0, cur_slot, dst_valid[1], 2'h0, src_dev[14:10]},
			32'h0000_0382);
		for (i = 0; i < 4000 && unload_valid !== 1'b1; i++)
			@(posedge sys_clk);
		chk({19'h0, cur_slot, unload_dev}, 32'h0000_0095);
		chk(32'(clash), 32'h0);
		conclude();
	end

	initial
	begin
		repeat (40000) @(posedge sys_clk);
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		conclude();
	end
endmodule
